// File: hw/cache_pkg.sv
// package: shared constants and types of the split cache subsystem
// assumes one core clock; the cache split strap is sampled while rst is high
`default_nettype none
package cache_pkg;
  localparam int WORD_W = 32;
  localparam int TAG_W = 20;            // address bits [31:12] kept as tag
  localparam int LINE_WORDS = 4;        // 16-byte instruction line
  localparam int I_LINES = 1024;        // 16kB instruction side at most
  localparam int I_WORDS = I_LINES * LINE_WORDS;
  localparam int D_WORDS = 2048;        // 8kB data side at most
  localparam int WB_DEPTH = 4;
  localparam int RB_DEPTH = 4;
  localparam int WB_W = 2 * WORD_W;     // address and data of one store
  localparam logic SPLIT_16K_4K = 1'b0; // reset value of the split strap
  localparam logic SPLIT_8K_8K = 1'b1;
  localparam logic [2:0] QUAD_LAST = 3'h3;
  localparam logic [2:0] SINGLE_LAST = 3'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_READ = 3'b010,
    S_FILL = 3'b100
  } state_t;
endpackage
`default_nettype wire

// File: hw/split_cache.sv
// split instruction/data cache with write buffer and refill read buffer
// assumes cpu holds a request until answered and memory obeys rd/wr handshakes
`default_nettype none
// Summary of operation
// - storage is split 16kB instruction / 4kB data by default, or 8kB / 8kB when selected.
// - an instruction line is four 32-bit words.
// - the instruction cache is direct mapped over the full 32-bit physical space.
// - index and tag come only from the physical address, so no flush is needed on a context change.
// - each instruction entry stores a parity bit over its word and tag.
// - parity is computed over each refill word and stored with it.
// - a parity mismatch on lookup is handled as an ordinary miss.
// - the data cache holds one word per line, 4kB by default.
// - the data cache is direct mapped and physically addressed over the full space.
// - each data entry stores a parity bit over its word and tag.
// - every store is also sent to memory.
// - a four-deep write buffer queues stores in order and retires them as memory accepts.
// - misses fetch one word for data and four words for instructions by handshake or burst.
// - a four-deep read buffer collects refill words, then fills the cache in one run.
// - writes by another bus master invalidate a matching data entry.
module split_cache
  import cache_pkg::*;
(
  input wire logic clk,                   // core clock
  input wire logic rst,                   // synchronous reset, high
  input wire logic ce,                    // clock enable
  input wire logic split_sel,             // 1 selects 8k/8k, sampled in reset
  input wire logic i_req,                 // fetch request, held
  input wire logic [31:0] i_addr,         // fetch address
  output logic i_valid,                   // fetch answered, pulse
  output logic [31:0] i_data,             // fetched word
  input wire logic d_rd,                  // load request, held
  input wire logic d_wr,                  // store request, held
  input wire logic [31:0] d_addr,         // load/store address
  input wire logic [31:0] d_wdata,        // store data
  output logic d_ack,                     // load/store answered, pulse
  output logic [31:0] d_rdata,            // loaded word
  output logic d_stall,                   // store held off, buffer full
  output logic rd_req,                    // bus read request, level
  output logic [31:0] rd_addr,            // bus read address
  output logic rd_quad,                   // 1 quad read, 0 single
  input wire logic mem_rvalid,            // read word present
  input wire logic [31:0] mem_rdata,      // read word
  output logic wr_req,                    // bus write request, level
  output logic [31:0] wr_addr,            // bus write address
  output logic [31:0] wr_data,            // bus write data
  input wire logic mem_wack,              // write taken by memory
  input wire logic snoop_wr,              // other master writes memory
  input wire logic [31:0] snoop_addr      // address of that write
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] iline(input logic mode, input logic [31:0] a);
    return (mode == SPLIT_8K_8K) ? {1'b0, a[12:4]} : a[13:4];
  endfunction
  function automatic logic [10:0] dword(input logic mode, input logic [31:0] a);
    return (mode == SPLIT_8K_8K) ? a[12:2] : {1'b0, a[11:2]};
  endfunction
  function automatic logic par(input logic [31:0] a, input logic [31:0] w);
    return ^{a[31:12], w};
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] i_mem [I_WORDS];
  logic [TAG_W-1:0] i_tag [I_LINES];
  logic i_par [I_WORDS];
  logic [WORD_W-1:0] d_mem [D_WORDS];
  logic [TAG_W-1:0] d_tag [D_WORDS];
  logic d_par [D_WORDS];
  logic [I_LINES-1:0] i_vld, next_i_vld;
  logic [D_WORDS-1:0] d_vld, next_d_vld;
  logic split_mode;

  state_t state, next_state;
  logic [2:0] rx_cnt, next_rx_cnt, fill_cnt, next_fill_cnt;
  logic next_rd_req, next_rd_quad, next_i_valid, next_d_ack, next_d_stall;
  logic [31:0] next_rd_addr, next_i_data, next_d_rdata;
  logic next_wr_req;
  logic [31:0] next_wr_addr, next_wr_data;
  logic iw_en, dw_en;
  logic [11:0] iw_idx;
  logic [10:0] dw_idx;
  logic [31:0] dw_addr, dw_data;

  logic [9:0] il;
  logic [11:0] iw;
  logic [10:0] dw;
  logic i_hit, i_tag_ok, i_par_ok, d_hit, d_tag_ok, d_par_ok;
  logic wb_in_ready, wb_out_valid, wb_out_ready, wb_push;
  logic [WB_W-1:0] wb_out;
  logic rb_out_valid, rb_in_valid, rb_out_ready;
  logic [31:0] rb_out;
  logic [2:0] rx_last;
  logic idle_free;

  assign il = iline(split_mode, i_addr);
  assign iw = {il, i_addr[3:2]};
  assign dw = dword(split_mode, d_addr);
  assign i_tag_ok = i_vld[il] && (i_tag[il] == i_addr[31:12]);
  assign i_par_ok = i_par[iw] == par(i_addr, i_mem[iw]);
  assign i_hit = i_tag_ok && i_par_ok;
  assign d_tag_ok = d_vld[dw] && (d_tag[dw] == d_addr[31:12]);
  assign d_par_ok = d_par[dw] == par(d_addr, d_mem[dw]);
  assign d_hit = d_tag_ok && d_par_ok;
  assign idle_free = (state == S_IDLE) && !i_valid && !d_ack;
  assign wb_push = idle_free && d_wr && wb_in_ready;
  assign wb_out_ready = !wr_req || mem_wack;
  assign rb_in_valid = (state == S_READ) && mem_rvalid;
  assign rb_out_ready = state == S_FILL;
  assign rx_last = rd_quad ? QUAD_LAST : SINGLE_LAST;

  // ---------------------------------------------------------------
  // buffers
  // ---------------------------------------------------------------
  word_fifo #(.WIDTH(WB_W), .DEPTH(WB_DEPTH)) u_wbuf (
    .clk(clk), .rst(rst), .ce(ce),
    .in_valid(wb_push), .in_ready(wb_in_ready), .in_data({d_addr, d_wdata}),
    .out_valid(wb_out_valid), .out_ready(wb_out_ready), .out_data(wb_out)
  );
  // words never exceed four per miss, so the read buffer cannot overflow
  word_fifo #(.WIDTH(WORD_W), .DEPTH(RB_DEPTH)) u_rbuf (
    .clk(clk), .rst(rst), .ce(ce),
    .in_valid(rb_in_valid), .in_ready(), .in_data(mem_rdata),
    .out_valid(rb_out_valid), .out_ready(rb_out_ready), .out_data(rb_out)
  );

  // ---------------------------------------------------------------
  // control
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_rx_cnt = rx_cnt;
    next_fill_cnt = fill_cnt;
    next_rd_req = rd_req;
    next_rd_addr = rd_addr;
    next_rd_quad = rd_quad;
    next_i_valid = 1'b0;
    next_i_data = i_data;
    next_d_ack = 1'b0;
    next_d_rdata = d_rdata;
    next_d_stall = 1'b0;
    next_i_vld = i_vld;
    next_d_vld = d_vld;
    iw_en = 1'b0;
    iw_idx = {iline(split_mode, rd_addr), fill_cnt[1:0]};
    dw_en = 1'b0;
    dw_idx = dw;
    dw_addr = d_addr;
    dw_data = d_wdata;
    case (state)
      S_IDLE: begin
        // data side first; the fetch waits until the data request is answered and dropped when both ask
        if (idle_free && d_wr) begin
          if (wb_in_ready) begin
            dw_en = 1'b1;
            next_d_vld[dw] = 1'b1;
            next_d_ack = 1'b1;
          end else begin
            next_d_stall = 1'b1;
          end
        end else if (idle_free && d_rd) begin
          if (d_hit) begin
            next_d_ack = 1'b1;
            next_d_rdata = d_mem[dw];
          end else begin
            next_d_vld[dw] = 1'b0;
            next_rd_req = 1'b1;
            next_rd_addr = {d_addr[31:2], 2'b00};
            next_rd_quad = 1'b0;
            next_rx_cnt = '0;
            next_state = S_READ;
          end
        end else if (idle_free && i_req) begin
          if (i_hit) begin
            next_i_valid = 1'b1;
            next_i_data = i_mem[iw];
          end else begin
            next_i_vld[il] = 1'b0;
            next_rd_req = 1'b1;
            next_rd_addr = {i_addr[31:4], 4'h0};
            next_rd_quad = 1'b1;
            next_rx_cnt = '0;
            next_state = S_READ;
          end
        end
      end
      S_READ: begin
        if (mem_rvalid) begin
          next_rx_cnt = 3'(rx_cnt + 1'b1);
          if (rx_cnt == rx_last) begin
            next_rd_req = 1'b0;
            next_fill_cnt = '0;
            next_state = S_FILL;
          end
        end
      end
      S_FILL: begin
        dw_idx = dword(split_mode, rd_addr);
        dw_addr = rd_addr;
        dw_data = rb_out;
        if (rb_out_valid) begin
          next_fill_cnt = 3'(fill_cnt + 1'b1);
          if (rd_quad) begin
            iw_en = 1'b1;
          end else begin
            dw_en = 1'b1;
          end
          if (fill_cnt == rx_last) begin
            if (rd_quad) begin
              next_i_vld[iline(split_mode, rd_addr)] = 1'b1;
            end else begin
              next_d_vld[dw_idx] = 1'b1;
            end
            next_state = S_IDLE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    // a foreign write wins over a same-cycle fill of that word only if the stored d_tag already matches its address
    if (snoop_wr && d_tag[dword(split_mode, snoop_addr)] == snoop_addr[31:12]) begin
      next_d_vld[dword(split_mode, snoop_addr)] = 1'b0;
    end
  end

  always_comb begin
    next_wr_req = wr_req;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (wb_out_ready) begin
      next_wr_req = wb_out_valid;
      if (wb_out_valid) begin
        next_wr_addr = wb_out[WB_W-1:WORD_W];
        next_wr_data = wb_out[WORD_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      split_mode <= split_sel;
      state <= S_IDLE;
      rx_cnt <= '0;
      fill_cnt <= '0;
      rd_req <= 1'b0;
      rd_addr <= '0;
      rd_quad <= 1'b0;
      i_valid <= 1'b0;
      i_data <= '0;
      d_ack <= 1'b0;
      d_rdata <= '0;
      d_stall <= 1'b0;
      wr_req <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      i_vld <= '0;
      d_vld <= '0;
    end else if (ce) begin
      state <= next_state;
      rx_cnt <= next_rx_cnt;
      fill_cnt <= next_fill_cnt;
      rd_req <= next_rd_req;
      rd_addr <= next_rd_addr;
      rd_quad <= next_rd_quad;
      i_valid <= next_i_valid;
      i_data <= next_i_data;
      d_ack <= next_d_ack;
      d_rdata <= next_d_rdata;
      d_stall <= next_d_stall;
      wr_req <= next_wr_req;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      i_vld <= next_i_vld;
      d_vld <= next_d_vld;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && iw_en) begin
      i_mem[iw_idx] <= rb_out;
      i_par[iw_idx] <= par(rd_addr, rb_out);
      i_tag[iw_idx[11:2]] <= rd_addr[31:12];
    end
    if (ce && dw_en) begin
      d_mem[dw_idx] <= dw_data;
      d_par[dw_idx] <= par(dw_addr, dw_data);
      d_tag[dw_idx] <= dw_addr[31:12];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_par_miss;
    @(posedge clk) disable iff (rst || !ce)
    (idle_free && !d_rd && !d_wr && i_req && i_tag_ok && !i_par_ok) |=> rd_req && rd_quad && !i_valid;
  endproperty
  a_par_miss: assert property (p_par_miss) else $error("parity error not handled as miss");

  property p_full_stall;
    @(posedge clk) disable iff (rst || !ce)
    (idle_free && d_wr && !wb_in_ready) |=> d_stall && !d_ack;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("store to full buffer not stalled");

  property p_store_fwd;
    @(posedge clk) disable iff (rst || !ce)
    wb_push && !wb_out_valid && !wr_req |=> ##1 wr_req && wr_addr == $past(d_addr, 2);
  endproperty
  a_store_fwd: assert property (p_store_fwd) else $error("store not forwarded to memory");

  property p_split_hold;
    @(posedge clk) disable iff (rst)
    1'b1 |=> $stable(split_mode);
  endproperty
  a_split_hold: assert property (p_split_hold) else $error("cache split changed outside reset");

  property p_quad_fill;
    @(posedge clk) disable iff (rst || !ce)
    (state == S_READ && rd_quad && mem_rvalid && rx_cnt == QUAD_LAST) |=> (state == S_FILL)[*4] ##1 state == S_IDLE;
  endproperty
  a_quad_fill: assert property (p_quad_fill) else $error("quad refill not a four-word run");

  property p_fill_par;
    @(posedge clk) disable iff (rst || !ce)
    iw_en |=> i_par[$past(iw_idx)] == ^{$past(rd_addr[31:12]), $past(rb_out)};
  endproperty
  a_fill_par: assert property (p_fill_par) else $error("refill parity wrong");

  property p_snoop;
    @(posedge clk) disable iff (rst || !ce)
    snoop_wr && d_tag[dword(split_mode, snoop_addr)] == snoop_addr[31:12] |=> !d_vld[dword(split_mode, $past(snoop_addr))];
  endproperty
  a_snoop: assert property (p_snoop) else $error("snooped entry still valid");

  property p_d_hit;
    @(posedge clk) disable iff (rst || !ce)
    idle_free && !d_wr && d_rd && d_hit |=> d_ack && d_rdata == $past(d_mem[dw]) && !rd_req;
  endproperty
  a_d_hit: assert property (p_d_hit) else $error("data hit not answered");

  property p_single_rd;
    @(posedge clk) disable iff (rst || !ce)
    idle_free && !d_wr && d_rd && !d_hit |=> rd_req && !rd_quad && rd_addr[1:0] == 2'b00;
  endproperty
  a_single_rd: assert property (p_single_rd) else $error("data miss not a single read");
endmodule
`default_nettype wire

// File: hw/word_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes clk/rst/ce shared with the instantiating block
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,                // core clock
  input wire logic rst,                // synchronous reset
  input wire logic ce,                 // clock enable
  input wire logic in_valid,           // source offers a word
  output logic in_ready,               // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid,              // a word is held
  input wire logic out_ready,          // drain takes the word
  output logic [WIDTH-1:0] out_data    // oldest word
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign in_ready = count != CW'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: sim/mem_model.sv
// memory side of the cache: answers bus reads with one or four words, bus writes with an ack
// assumes the cache holds rd_req and wr_req as levels and samples our outputs on the rising edge
`default_nettype none
module mem_model (
  input wire logic clk,              // core clock
  input wire logic rst,              // synchronous reset, high
  input wire logic rd_req,           // read request level
  input wire logic [31:0] rd_addr,   // read address
  input wire logic rd_quad,          // four words when high
  input wire logic wr_req,           // write request level
  input wire logic [31:0] wr_addr,   // write address
  input wire logic [31:0] wr_data,   // write data
  input wire logic [3:0] rd_gap,     // idle cycles before each read word, 0 is burst
  input wire logic [3:0] wr_wait,    // cycles before a write is taken
  output logic mem_rvalid,           // read word present
  output logic [31:0] mem_rdata,     // read word
  output logic mem_wack              // write taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [31:0]];
  int sent = 0;
  int gap_cnt = 0;
  int wr_cnt = 0;

  function automatic logic [31:0] word_at(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : (a ^ 32'h3C5A_0F96);
  endfunction

  initial begin
    mem_rvalid = 1'b0;
    mem_rdata = 32'h0;
    mem_wack = 1'b0;
  end

  // ----------------------------------------
  // read and write answers, launched on the falling edge
  // ----------------------------------------
  always @(negedge clk) begin
    if (rst || !rd_req) begin
      mem_rvalid <= 1'b0;
      sent = 0;
      gap_cnt = int'(rd_gap);
      mem_rdata <= ~mem_rdata; // released data lines never keep the last word
    end else if (sent < (rd_quad ? 4 : 1) && gap_cnt == 0) begin
      mem_rvalid <= 1'b1;
      mem_rdata <= word_at(rd_addr + 32'(4 * sent));
      sent = sent + 1;
      gap_cnt = int'(rd_gap);
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (gap_cnt > 0) gap_cnt = gap_cnt - 1;
    end
  end

  always @(negedge clk) begin
    if (rst || mem_wack || !wr_req) begin
      mem_wack <= 1'b0;
      wr_cnt = 0;
    end else if (wr_cnt >= int'(wr_wait)) begin
      mem_wack <= 1'b1;
      mem[wr_addr] = wr_data;
    end else begin
      wr_cnt = wr_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench of the split cache with a memory model on the bus side
// assumes cache_pkg, split_cache and mem_model are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cache_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, split_sel = SPLIT_16K_4K;
  logic i_req = 1'b0, i_valid, d_rd = 1'b0, d_wr = 1'b0, d_ack, d_stall;
  logic [31:0] i_addr = 32'h0, i_data, d_addr = 32'h0, d_wdata = 32'h0, d_rdata;
  logic rd_req, rd_quad, mem_rvalid, wr_req, mem_wack, snoop_wr = 1'b0;
  logic [31:0] rd_addr, mem_rdata, wr_addr, wr_data, snoop_addr = 32'h0, last_rd_addr = 32'h0;
  logic [3:0] rd_gap = 4'h0, wr_wait = 4'h0;
  logic rd_seen = 1'b0, last_rd_quad = 1'b0;
  logic [63:0] wq [$];
  int bad_count = 0, n_compared = 0, cyc = 0, n_reads = 0, n_stalls = 0;

  split_cache split_cache_i (.clk(clk), .rst(rst), .ce(ce), .split_sel(split_sel), .i_req(i_req),
    .i_addr(i_addr), .i_valid(i_valid), .i_data(i_data), .d_rd(d_rd), .d_wr(d_wr), .d_addr(d_addr),
    .d_wdata(d_wdata), .d_ack(d_ack), .d_rdata(d_rdata), .d_stall(d_stall), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_quad(rd_quad), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .mem_wack(mem_wack),
    .snoop_wr(snoop_wr), .snoop_addr(snoop_addr));
  mem_model mem_model_i (.clk(clk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr), .rd_quad(rd_quad),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .rd_gap(rd_gap), .wr_wait(wr_wait),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_wack(mem_wack));

  always #50 clk = ~clk;

  // ----------------------------------------
  // bus monitors and run limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (rd_req && !rd_seen) begin
      n_reads++;
      last_rd_addr = rd_addr;
      last_rd_quad = rd_quad;
    end
    rd_seen = rd_req;
    if (wr_req && mem_wack) wq.push_back({wr_addr, wr_data});
    if (d_stall) n_stalls++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ 32'h3C5A_0F96;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // kind 0 fetch, 1 load, 2 store; request held until answered, dropped in the answer cycle
  task automatic cpu_op(input int kind, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(negedge clk);
    i_addr = a;
    d_addr = a;
    d_wdata = wd;
    i_req = (kind == 0);
    d_rd = (kind == 1);
    d_wr = (kind == 2);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (i_valid !== 1'b1 && d_ack !== 1'b1 && n < 200);
    rd = (kind == 0) ? i_data : d_rdata;
    check("answer in time", 32'h1, {31'h0, n < 200});
    @(negedge clk);
    i_req = 1'b0;
    d_rd = 1'b0;
    d_wr = 1'b0;
  endtask

  // split strap moves one cycle after release to show it is only taken in reset
  task automatic do_reset(input logic sel);
    @(negedge clk);
    rst = 1'b1;
    split_sel = sel;
    repeat (8) @(negedge clk);
    check("reset outputs", 32'h0, {28'h0, i_valid, d_ack, rd_req, wr_req});
    rst = 1'b0;
    @(negedge clk);
    split_sel = ~sel;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_fetch(input logic [31:0] base, input logic [3:0] gap);
    logic [31:0] v;
    int r0;
    rd_gap = gap;
    r0 = n_reads;
    cpu_op(0, base + 32'h8, 32'h0, v);
    check("fetch miss word", pat(base + 32'h8), v);
    check("quad read", 32'h1, {31'h0, last_rd_quad});
    check("line address", base, last_rd_addr);
    for (int k = 0; k < 4; k++) begin
      cpu_op(0, base + 32'(4 * k), 32'h0, v);
      check("fetch hit word", pat(base + 32'(4 * k)), v);
    end
    check("fetch bus reads", 32'(r0 + 1), 32'(n_reads));
    rd_gap = 4'h0;
  endtask

  // lines 0x1230 and 0x3230 share an index only when the instruction side is 8kB
  task automatic t_ialias(input int conflict);
    logic [31:0] v;
    int r0;
    t_fetch(32'h0000_1230, 4'h3);
    t_fetch(32'h0000_3230, 4'h0);
    r0 = n_reads;
    cpu_op(0, 32'h0000_1234, 32'h0, v);
    check("fetch after alias", pat(32'h0000_1234), v);
    check("fetch alias bus reads", 32'(r0 + conflict), 32'(n_reads));
  endtask

  task automatic t_map(input logic [31:0] a, input int conflict);
    logic [31:0] v;
    int r0;
    r0 = n_reads;
    cpu_op(1, a, 32'h0, v);
    check("load miss word", pat(a), v);
    check("single read", 32'h0, {31'h0, last_rd_quad});
    check("word address", a, last_rd_addr);
    cpu_op(1, a + 32'h1000, 32'h0, v);
    check("alias word", pat(a + 32'h1000), v);
    cpu_op(1, a, 32'h0, v);
    check("load after alias", pat(a), v);
    check("alias bus reads", 32'(r0 + 2 + conflict), 32'(n_reads));
  endtask

  task automatic t_stores();
    logic [31:0] v;
    int s0, r0, n;
    wr_wait = 4'h9;
    s0 = n_stalls;
    wq.delete();
    for (int i = 0; i < 6; i++) cpu_op(2, 32'h0000_0400 + 32'(4 * i), 32'hA000_0000 + 32'(i), v);
    check("store stall seen", 32'h1, {31'h0, n_stalls > s0});
    n = 0;
    while (wq.size() < 6 && n < 300) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    check("writes retired", 32'h6, 32'(wq.size()));
    for (int i = 0; i < 6 && i < wq.size(); i++) begin
      check("write address", 32'h0000_0400 + 32'(4 * i), wq[i][63:32]);
      check("write data", 32'hA000_0000 + 32'(i), wq[i][31:0]);
    end
    r0 = n_reads;
    cpu_op(1, 32'h0000_0408, 32'h0, v);
    check("load of stored word", 32'hA000_0002, v);
    check("stored word hit", 32'(r0), 32'(n_reads));
    wr_wait = 4'h0;
  endtask

  task automatic t_snoop();
    logic [31:0] v;
    int r0;
    cpu_op(1, 32'h0000_2468, 32'h0, v);
    r0 = n_reads;
    @(negedge clk);
    snoop_addr = 32'h0000_3468;
    snoop_wr = 1'b1;
    @(negedge clk);
    snoop_wr = 1'b0;
    cpu_op(1, 32'h0000_2468, 32'h0, v);
    check("other tag snoop keeps entry", 32'(r0), 32'(n_reads));
    @(negedge clk);
    snoop_addr = 32'h0000_2468;
    snoop_wr = 1'b1;
    @(negedge clk);
    snoop_wr = 1'b0;
    cpu_op(1, 32'h0000_2468, 32'h0, v);
    check("snooped entry refetched", 32'(r0 + 1), 32'(n_reads));
    check("refetched word", pat(32'h0000_2468), v);
  endtask

  initial begin
    do_reset(SPLIT_16K_4K);
    t_fetch(32'hFFFF_FFF0, 4'h0);
    t_ialias(0);
    t_map(32'h8000_0010, 1);
    t_stores();
    t_snoop();
    do_reset(SPLIT_8K_8K);
    t_map(32'h8000_0010, 0);
    t_ialias(1);
    close_out();
  end
endmodule
`default_nettype wire
